// >>> rtl/lane_align_defs.svh
// Purpose: Offsets, field positions and reset values of the lane alignment status block
// Assumes: Byte-wide register port, 12-bit register addresses
// Notes: Included by bare name; definitions only
//
// What this block does
// - Lane zero frame alignment shown as read-only bit
// - Eight-bit read-only checksum result, resets to zero
// - Checksum bit one on agreement, zero otherwise
// - Eight-bit read-only initial alignment register, reset zero
`ifndef LANE_ALIGN_DEFS_SVH
`define LANE_ALIGN_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define LA_ADDR_W 12
`define LA_OFS_FRAME_ALIGN 12'h471
`define LA_OFS_CHECKSUM 12'h472
`define LA_OFS_INIT_ALIGN 12'h473
`define LA_OFS_CONTROL 12'h474
`define LA_OFS_EVENT_STATUS 12'h478
`define LA_OFS_EVENT_MASK 12'h479

// ----------------------------------------------------------------
// Reset values and fields
// ----------------------------------------------------------------
`define LA_RST_STATUS 8'h00
`define LA_RST_CONTROL 8'h00
`define LA_RST_MASK 4'h0
`define LA_UNMAPPED_DATA 8'h00
`define LA_CTRL_SKIP_BIT 0
`define LA_EVT_FRAME_LOST 0
`define LA_EVT_INIT_LOST 1
`define LA_EVT_CKS_BAD 2
`define LA_EVT_CKS_DONE 3
`define LA_EVT_W 4

`endif

// >>> rtl/lane_align_pkg.sv
// Purpose: Types shared by the lane alignment status modules
// Assumes: Nothing beyond SystemVerilog packages
// Notes: Used only by scoped reference
`default_nettype none

package lane_align_pkg;

    // Checksum walker states, Gray from IDLE to ACCUM to CHECK; CHECK back to IDLE flips both bits
    typedef enum logic [1:0]
    {
        CKS_IDLE = 2'b00,
        CKS_ACCUM = 2'b01,
        CKS_CHECK = 2'b11
    } cks_state_t;

    typedef logic [7:0] octet_t;

endpackage

`default_nettype wire

// >>> rtl/checksum_lane_if.sv
// Purpose: Carrier for one lane's alignment configuration octets and checksum result
// Assumes: Single clock shared by both ends
// Notes: Producer is the status block top, consumer is the checksum unit
`default_nettype none

interface checksum_lane_if;
    lane_align_pkg::octet_t octet;
    logic octet_valid;
    logic octet_first;
    logic octet_is_checksum;
    logic result_valid;
    logic result_ok;

    modport source
    (
        output octet, octet_valid, octet_first, octet_is_checksum,
        input result_valid, result_ok
    );
    modport sink
    (
        input octet, octet_valid, octet_first, octet_is_checksum,
        output result_valid, result_ok
    );
endinterface

`default_nettype wire

// >>> rtl/lane_checksum_unit.sv
// Purpose: Sums one lane's alignment configuration octets and checks the received checksum
// Assumes: Octets arrive first-flagged, checksum octet flagged, on the system clock
// Notes: One result pulse per checksum octet; sum is modulo 256
`include "lane_align_defs.svh"
`default_nettype none

module lane_checksum_unit
(
    input wire logic clock_i, // System clock
    input wire logic reset_n_i, // Asynchronous reset, active low
    checksum_lane_if.sink lane // Octet stream in, result out
);

    lane_align_pkg::cks_state_t state;
    lane_align_pkg::octet_t sum;
    lane_align_pkg::octet_t base;

    // Running sum restarts on the first octet of a configuration
    always_comb
    begin
        base = (lane.octet_first) ? 8'h00 : sum;
    end

    // Walk through a configuration, accumulating until the checksum octet
    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state <= lane_align_pkg::CKS_IDLE;
            sum <= 8'h00;
        end
        else
        begin
            case (state)
                lane_align_pkg::CKS_IDLE,
                lane_align_pkg::CKS_CHECK:
                begin
                    if (lane.octet_valid && lane.octet_first && !lane.octet_is_checksum)
                    begin
                        sum <= lane.octet;
                        state <= lane_align_pkg::CKS_ACCUM;
                    end
                    else
                    begin
                        state <= lane_align_pkg::CKS_IDLE;
                    end
                end
                lane_align_pkg::CKS_ACCUM:
                begin
                    if (lane.octet_valid && lane.octet_is_checksum)
                    begin
                        state <= lane_align_pkg::CKS_CHECK;
                    end
                    else if (lane.octet_valid)
                    begin
                        sum <= base + lane.octet;
                    end
                end
                default:
                begin
                    state <= lane_align_pkg::CKS_IDLE;
                end
            endcase
        end
    end

    // Compare computed sum against received checksum octet
    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            lane.result_valid <= 1'b0;
            lane.result_ok <= 1'b0;
        end
        else
        begin
            lane.result_valid <= 1'b0;
            if (state == lane_align_pkg::CKS_ACCUM && lane.octet_valid && lane.octet_is_checksum)
            begin
                lane.result_valid <= 1'b1;
                lane.result_ok <= (sum == lane.octet);
            end
        end
    end

endmodule

`default_nettype wire

// >>> rtl/event_status_unit.sv
// Purpose: Sticky event bits, mask, and level interrupt
// Assumes: Clear-on-read strobe comes from the register decode
// Notes: A set in the clearing cycle survives the clear
`default_nettype none

module event_status_unit
#(
    parameter int WIDTH = 4
)
(
    input wire logic clock_i, // System clock
    input wire logic reset_n_i, // Asynchronous reset, active low
    input wire logic [WIDTH-1:0] event_i, // One-cycle event pulses
    input wire logic clear_i, // Read of status register
    input wire logic [WIDTH-1:0] mask_i, // Enabled events
    output logic [WIDTH-1:0] status_o, // Sticky event bits
    output logic irq_o // Level interrupt
);

    // Sticky bits: set wins over clear-on-read
    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            status_o <= '0;
        end
        else
        begin
            status_o <= (clear_i ? '0 : status_o) | event_i;
        end
    end

    // Interrupt follows unmasked sticky bits, registered
    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            irq_o <= 1'b0;
        end
        else
        begin
            irq_o <= |(((clear_i ? '0 : status_o) | event_i) & mask_i);
        end
    end

endmodule

`default_nettype wire

// >>> rtl/serial_lane_align_status.sv
// Purpose: Per-lane frame, initial alignment and checksum status for a multi-lane deframer
// Assumes: Lane status and octet strobes come from deframer logic on clock_i
// Notes: Registers are read-only except control and event mask
//
// Local design decision: the strobed register port.
`include "lane_align_defs.svh"
`default_nettype none

module serial_lane_align_status
#(
    parameter int LANES = 8
)
(
    input wire logic clock_i, // System clock, 100 MHz
    input wire logic reset_n_i, // Asynchronous reset, active low
    input wire logic [`LA_ADDR_W-1:0] addr_i, // Register address
    input wire logic [7:0] wdata_i, // Write data
    input wire logic wr_i, // Write strobe
    input wire logic rd_i, // Read strobe
    output logic [7:0] rdata_o, // Read data, cycle after strobe
    input wire logic [LANES-1:0] frame_aligned_i, // Deframer frame alignment per lane
    input wire logic [LANES-1:0] initial_aligned_i, // Deframer initial alignment per lane
    input wire logic [LANES-1:0] cfg_valid_i, // Alignment config octet strobe per lane
    input wire logic [LANES-1:0] cfg_first_i, // First config octet per lane
    input wire logic [LANES-1:0] cfg_is_checksum_i, // Checksum octet per lane
    input wire logic [LANES*8-1:0] cfg_octet_i, // Config octets, lane n at [8n+7:8n]
    output logic skip_alignment_sequence_o, // Alignment sequence disabled
    output logic irq_o // Interrupt, high while unmasked event set
);

    // ----------------------------------------------------------------
    // Status storage
    // ----------------------------------------------------------------
    logic [LANES-1:0] lane_frame_align_state;
    logic [LANES-1:0] lane_checksum_result;
    logic [LANES-1:0] lane_initial_align_state;
    logic [LANES-1:0] cks_done;
    logic [LANES-1:0] cks_ok;
    logic [7:0] control;
    logic [`LA_EVT_W-1:0] event_mask;
    logic [`LA_EVT_W-1:0] event_status;
    logic [`LA_EVT_W-1:0] events;
    logic status_read;
    logic irq;
    logic [7:0] next_rdata;
    logic [7:0] frame_view;
    logic [7:0] checksum_view;
    logic [7:0] initial_view;
    logic hit_frame;
    logic hit_checksum;
    logic hit_initial;
    logic hit_control;
    logic hit_status;
    logic hit_mask;
    logic frame_lost;
    logic initial_lost;
    logic check_failed;
    logic check_finished;

    // ----------------------------------------------------------------
    // Checksum units, one per lane
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < LANES; g++)
        begin : gen_lane
            checksum_lane_if cks ();

            assign cks.octet = cfg_octet_i[g*8 +: 8];
            assign cks.octet_valid = cfg_valid_i[g];
            assign cks.octet_first = cfg_first_i[g];
            assign cks.octet_is_checksum = cfg_is_checksum_i[g];
            assign cks_done[g] = cks.result_valid;
            assign cks_ok[g] = cks.result_ok;

            lane_checksum_unit u_cks
            (
                .clock_i(clock_i),
                .reset_n_i(reset_n_i),
                .lane(cks.sink)
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Lane status
    // ----------------------------------------------------------------
    // Track frame alignment per lane; bit zero is lane zero
    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            lane_frame_align_state <= '0;
        end
        else
        begin
            lane_frame_align_state <= frame_aligned_i;
        end
    end

    // Latch checksum verdict per lane when its check finishes
    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            lane_checksum_result <= '0;
        end
        else
        begin
            for (int i = 0; i < LANES; i++)
            begin
                if (cks_done[i])
                begin
                    lane_checksum_result[i] <= cks_ok[i];
                end
            end
        end
    end

    // Track initial lane alignment per lane
    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            lane_initial_align_state <= '0;
        end
        else
        begin
            lane_initial_align_state <= initial_aligned_i;
        end
    end

    // ----------------------------------------------------------------
    // Register views
    // ----------------------------------------------------------------
    // Eight-bit views of the lane bits; bits above LANES read zero
    generate
        for (g = 0; g < 8; g++)
        begin : gen_view
            if (g < LANES)
            begin : gen_used
                assign frame_view[g] = lane_frame_align_state[g];
                assign checksum_view[g] = lane_checksum_result[g];
                assign initial_view[g] = lane_initial_align_state[g];
            end
            else
            begin : gen_unused
                assign frame_view[g] = 1'b0;
                assign checksum_view[g] = 1'b0;
                assign initial_view[g] = 1'b0;
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Events and interrupt
    // ----------------------------------------------------------------
    // One flag per kind of event, from level drops and check results
    always_comb
    begin
        frame_lost = |(lane_frame_align_state & ~frame_aligned_i);
        initial_lost = |(lane_initial_align_state & ~initial_aligned_i);
        check_failed = |(cks_done & ~cks_ok);
        check_finished = |cks_done;
    end

    // Flags placed at their event status bits
    always_comb
    begin
        events = '0;
        events[`LA_EVT_FRAME_LOST] = frame_lost;
        events[`LA_EVT_INIT_LOST] = initial_lost;
        events[`LA_EVT_CKS_BAD] = check_failed;
        events[`LA_EVT_CKS_DONE] = check_finished;
    end

    // ----------------------------------------------------------------
    // Sticky status and interrupt
    // ----------------------------------------------------------------
    // Reading the status register clears its sticky bits
    assign status_read = rd_i && hit_status;

    event_status_unit #(.WIDTH(`LA_EVT_W)) u_evt
    (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .event_i(events),
        .clear_i(status_read),
        .mask_i(event_mask),
        .status_o(event_status),
        .irq_o(irq)
    );

    assign irq_o = irq;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    // Exact match only; any other offset is unmapped
    always_comb
    begin
        hit_frame = (addr_i == `LA_OFS_FRAME_ALIGN);
        hit_checksum = (addr_i == `LA_OFS_CHECKSUM);
        hit_initial = (addr_i == `LA_OFS_INIT_ALIGN);
        hit_control = (addr_i == `LA_OFS_CONTROL);
        hit_status = (addr_i == `LA_OFS_EVENT_STATUS);
        hit_mask = (addr_i == `LA_OFS_EVENT_MASK);
    end

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    // Control holds only the skip flag; other bits read zero
    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            control <= `LA_RST_CONTROL;
        end
        else if (wr_i && hit_control)
        begin
            control <= {7'h00, wdata_i[`LA_CTRL_SKIP_BIT]};
        end
    end

    // Mask selects which sticky events raise the interrupt
    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            event_mask <= `LA_RST_MASK;
        end
        else if (wr_i && hit_mask)
        begin
            event_mask <= wdata_i[`LA_EVT_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // Deframer control
    // ----------------------------------------------------------------
    // Skip flag drives the deframer; status bits then are advisory only
    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            skip_alignment_sequence_o <= 1'b0;
        end
        else
        begin
            skip_alignment_sequence_o <= control[`LA_CTRL_SKIP_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Register reads
    // ----------------------------------------------------------------
    // Read mux; unmapped addresses read zero
    always_comb
    begin
        next_rdata = `LA_UNMAPPED_DATA;
        if (hit_frame)
        begin
            next_rdata = frame_view;
        end
        else if (hit_checksum)
        begin
            next_rdata = checksum_view;
        end
        else if (hit_initial)
        begin
            next_rdata = initial_view;
        end
        else if (hit_control)
        begin
            next_rdata = control;
        end
        else if (hit_status)
        begin
            next_rdata = {4'h0, event_status};
        end
        else if (hit_mask)
        begin
            next_rdata = {4'h0, event_mask};
        end
        else
        begin
            next_rdata = `LA_UNMAPPED_DATA;
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rdata_o <= 8'h00;
        end
        else
        begin
            rdata_o <= rd_i ? next_rdata : 8'h00;
        end
    end

endmodule

`default_nettype wire

// >>> dv/lane_transmitter_model.sv
// Purpose: Far-end transmitter driving alignment levels and configuration octets
// Assumes: Same clock as the status block
// Notes: Idle octet lines carry a new pattern after the checksum, but hold the last data octet in slow gaps
`default_nettype none

module lane_transmitter_model
#(
    parameter int LANES = 8
)
(
    input wire logic clock_i, // System clock
    output logic [LANES-1:0] frame_aligned_o, // Frame alignment levels
    output logic [LANES-1:0] initial_aligned_o, // Initial alignment levels
    output logic [LANES-1:0] valid_o, // Octet strobes
    output logic [LANES-1:0] first_o, // First octet flags
    output logic [LANES-1:0] is_checksum_o, // Checksum octet flags
    output logic [LANES*8-1:0] octet_o // Octets, lane n at [8n+7:8n]
);
    timeunit 1ns;
    timeprecision 1ps;

    // Quiet link at time zero
    initial
    begin
        frame_aligned_o = '0;
        initial_aligned_o = '0;
        valid_o = '0;
        first_o = '0;
        is_checksum_o = '0;
        octet_o = {LANES{8'hA5}};
    end

    // Change alignment levels after an edge
    task automatic set_align(input logic [LANES-1:0] fa, input logic [LANES-1:0] ia);
        @(posedge clock_i);
        frame_aligned_o <= fa;
        initial_aligned_o <= ia;
    endtask

    // Three data octets then the checksum; slow drops the strobe between data octets
    task automatic send_config(input int lane, input logic bad, input logic slow);
        logic [7:0] sum;
        logic [7:0] val;
        sum = 8'h00;
        for (int i = 0; i < 3; i++)
        begin
            val = 8'(8'h31 * (i + 1) + lane);
            sum = sum + val;
            if (slow && i > 0)
            begin
                @(posedge clock_i);
                valid_o[lane] <= 1'b0;
            end
            @(posedge clock_i);
            valid_o[lane] <= 1'b1;
            first_o[lane] <= (i == 0);
            octet_o[lane*8 +: 8] <= val;
        end
        @(posedge clock_i);
        first_o[lane] <= 1'b0;
        is_checksum_o[lane] <= 1'b1;
        octet_o[lane*8 +: 8] <= bad ? ~sum : sum;
        @(posedge clock_i);
        valid_o[lane] <= 1'b0;
        is_checksum_o[lane] <= 1'b0;
        octet_o[lane*8 +: 8] <= sum ^ 8'h5A;
    endtask
endmodule

`default_nettype wire

// >>> dv/lane_align_checker.sv
// Purpose: Port-level checks of the lane alignment status registers
// Assumes: Read data stands in the cycle after the read strobe
// Notes: Bound to the status block top
`include "lane_align_defs.svh"
`default_nettype none

module lane_align_checker
#(
    parameter int LANES = 8
)
(
    input wire logic clock_i, // System clock
    input wire logic reset_n_i, // Reset, active low
    input wire logic [`LA_ADDR_W-1:0] addr_i, // Register address
    input wire logic rd_i, // Read strobe
    input wire logic [7:0] rdata_o, // Read data
    input wire logic [LANES-1:0] frame_aligned_i, // Frame alignment levels
    input wire logic [LANES-1:0] initial_aligned_i, // Initial alignment levels
    input wire logic [LANES-1:0] cfg_valid_i, // Octet strobes
    input wire logic [LANES-1:0] cfg_is_checksum_i // Checksum flags
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!reset_n_i);

    logic [1:0] age;
    logic seen_cks;

    // Edges since reset release, and any checksum octet seen
    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            age <= 2'h0;
            seen_cks <= 1'b0;
        end
        else
        begin
            age <= (age == 2'h3) ? age : age + 2'h1;
            seen_cks <= seen_cks | (|(cfg_valid_i & cfg_is_checksum_i));
        end
    end

    property p_frame_read;
        rd_i && addr_i == `LA_OFS_FRAME_ALIGN && age == 2'h3 && $stable(frame_aligned_i)
            && frame_aligned_i == $past(frame_aligned_i, 2) |=> rdata_o == 8'($past(frame_aligned_i));
    endproperty
    a_frame_read: assert property (p_frame_read) else $error("frame align readback wrong");

    property p_init_read;
        rd_i && addr_i == `LA_OFS_INIT_ALIGN && age == 2'h3 && $stable(initial_aligned_i)
            && initial_aligned_i == $past(initial_aligned_i, 2) |=> rdata_o == 8'($past(initial_aligned_i));
    endproperty
    a_init_read: assert property (p_init_read) else $error("initial align readback wrong");

    property p_cks_reset;
        rd_i && addr_i == `LA_OFS_CHECKSUM && !seen_cks |=> rdata_o == 8'h00;
    endproperty
    a_cks_reset: assert property (p_cks_reset) else $error("checksum bits not zero");

    property p_cks_hold;
        rd_i && addr_i == `LA_OFS_CHECKSUM && $past(rd_i, 2) && $past(addr_i, 2) == `LA_OFS_CHECKSUM
            && cfg_valid_i == '0 && $past(cfg_valid_i) == '0 && $past(cfg_valid_i, 2) == '0
            && $past(cfg_valid_i, 3) == '0 && $past(cfg_valid_i, 4) == '0 |=> rdata_o == $past(rdata_o, 2);
    endproperty
    a_cks_hold: assert property (p_cks_hold) else $error("checksum bits changed without a check");
endmodule

bind serial_lane_align_status lane_align_checker #(.LANES(LANES)) u_checker
(
    .clock_i,
    .reset_n_i,
    .addr_i,
    .rd_i,
    .rdata_o,
    .frame_aligned_i,
    .initial_aligned_i,
    .cfg_valid_i,
    .cfg_is_checksum_i
);

`default_nettype wire

// >>> dv/tb.sv
// Purpose: Register-level test of the lane alignment status block
// Assumes: Transmitter model drives the lane side
// Notes: Expected values come from the patterns sent
`include "lane_align_defs.svh"
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic clock_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [11:0] addr_i = 12'h000;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] rdata_o;
    logic [7:0] fa, ia, cv, cf, cc;
    logic [63:0] co;
    logic skip_alignment_sequence_o;
    logic irq_o;
    int n_mismatch = 0;
    int total_checks = 0;
    int cycles = 0;

    // 100 MHz clock
    always #5 clock_i = ~clock_i;

    lane_transmitter_model xmit
    (
        .clock_i(clock_i),
        .frame_aligned_o(fa),
        .initial_aligned_o(ia),
        .valid_o(cv),
        .first_o(cf),
        .is_checksum_o(cc),
        .octet_o(co)
    );

    serial_lane_align_status dut
    (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .wr_i(wr_i),
        .rd_i(rd_i),
        .rdata_o(rdata_o),
        .frame_aligned_i(fa),
        .initial_aligned_i(ia),
        .cfg_valid_i(cv),
        .cfg_first_i(cf),
        .cfg_is_checksum_i(cc),
        .cfg_octet_i(co),
        .skip_alignment_sequence_o(skip_alignment_sequence_o),
        .irq_o(irq_o)
    );

    // ----------------------------------------------------------------
    // Bus and compare tasks
    // ----------------------------------------------------------------
    task automatic reg_write(input logic [11:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask

    task automatic reg_read(input logic [11:0] a, output logic [7:0] d);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask

    task automatic expect_reg(input logic [11:0] a, input logic [7:0] exp);
        logic [7:0] got;
        reg_read(a, got);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR reg %h expected %h seen %h", a, exp, got);
        end
    endtask

    task automatic check_pin(input string what, input logic exp, input logic got);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask

    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Hang guard
    always @(posedge clock_i)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_mismatch++;
            wrap_up;
        end
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        logic [7:0] pats [4];
        logic [7:0] cks;
        pats = '{8'h01, 8'hA5, 8'h5A, 8'h00};
        repeat (6) @(posedge clock_i);
        reset_n_i <= 1'b1;
        expect_reg(`LA_OFS_FRAME_ALIGN, 8'h00);
        expect_reg(`LA_OFS_CHECKSUM, 8'h00);
        expect_reg(`LA_OFS_INIT_ALIGN, 8'h00);
        reg_write(`LA_OFS_CHECKSUM, 8'hFF);
        reg_write(`LA_OFS_INIT_ALIGN, 8'hFF);
        expect_reg(`LA_OFS_CHECKSUM, 8'h00);
        expect_reg(`LA_OFS_INIT_ALIGN, 8'h00);
        // Alignment levels gained and lost
        foreach (pats[k])
        begin
            xmit.set_align(pats[k], ~pats[k]);
            settle(2);
            expect_reg(`LA_OFS_FRAME_ALIGN, pats[k]);
            expect_reg(`LA_OFS_INIT_ALIGN, ~pats[k]);
        end
        // Good checksum on every lane, then a bad and a recovery on lane 3
        cks = 8'h00;
        for (int n = 0; n < 8; n++)
        begin
            xmit.send_config(n, 1'b0, n[0]);
            cks[n] = 1'b1;
            expect_reg(`LA_OFS_CHECKSUM, cks);
        end
        xmit.send_config(3, 1'b1, 1'b0);
        expect_reg(`LA_OFS_CHECKSUM, 8'hF7);
        expect_reg(`LA_OFS_CHECKSUM, 8'hF7);
        expect_reg(`LA_OFS_CHECKSUM, 8'hF7);
        xmit.send_config(3, 1'b0, 1'b1);
        expect_reg(`LA_OFS_CHECKSUM, 8'hFF);
        // Mismatch event raises the interrupt, read clears it
        expect_reg(`LA_OFS_EVENT_STATUS, 8'h0F);
        reg_write(`LA_OFS_EVENT_MASK, 8'h04);
        xmit.send_config(5, 1'b0, 1'b0);
        settle(3);
        check_pin("irq_o", 1'b0, irq_o);
        xmit.send_config(5, 1'b1, 1'b0);
        settle(3);
        check_pin("irq_o", 1'b1, irq_o);
        expect_reg(`LA_OFS_EVENT_STATUS, 8'h0C);
        settle(2);
        check_pin("irq_o", 1'b0, irq_o);
        expect_reg(`LA_OFS_CHECKSUM, 8'hDF);
        // Sequence skipped and restored: skip pin follows, control reads back only the skip bit
        reg_write(`LA_OFS_CONTROL, 8'hFF);
        settle(1);
        check_pin("skip", 1'b1, skip_alignment_sequence_o);
        expect_reg(`LA_OFS_CONTROL, 8'h01);
        reg_write(`LA_OFS_CONTROL, 8'h00);
        settle(1);
        check_pin("skip", 1'b0, skip_alignment_sequence_o);
        expect_reg(12'h47F, 8'h00);
        wrap_up;
    end
endmodule

`default_nettype wire
